// ---- pkg/nvc_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define NVC_OFS_PRESCALER 8'h00
`define NVC_OFS_OPTIONS 8'h04
`define NVC_OFS_CONFIG 8'h08
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define NVC_BIT_DIVISOR_LOADED_FLAG 7
`define NVC_BIT_PRESCALE_BY_EIGHT 6
`define NVC_DIV_MSB 5
`define NVC_BIT_LAYOUT 5
`define NVC_SEC_MSB 1
`define NVC_BIT_PAGESEL 6
`define NVC_BIT_KEYEN 5
// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define NVC_DIV_RST 6'h00
`define NVC_SEC_RST 2'h0
`define NVC_SEC_UNSECURED 2'h2
`define NVC_PRE8_LAST 3'h7
`define NVC_KEY_WIN_LO 16'hffb0
`define NVC_KEY_WIN_HI 16'hffb7
`define NVC_HTRANS_NONSEQ 2'h2
`define NVC_HTRANS_SEQ 2'h3
`endif

// ---- pkg/nvc_pkg.sv ----
// Types shared by the NVM clock, security and configuration block
package nvc_pkg;
  typedef logic [1:0] nvc_sec_t;
  typedef logic [15:0] nvc_pulse_cnt_t;
  typedef enum logic [1:0] {
    NVC_TMR_IDLE = 2'b01,
    NVC_TMR_RUN  = 2'b10
  } nvc_tmr_state_t;
endpackage

// ---- design/nvc_ctrl.sv ----
// NVM clock prescaler, security state and configuration with AHB-Lite slave
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`include "nvc_regs.svh"

// Contract
// (R01) Divisor-loaded flag clears on reset, sets on first prescaler write.
// (R02) Program and erase inhibited on both arrays while the flag is 0.
// (R03) Prescale-by-eight accepted once after reset; selects bus clock or /8.
// (R04) NVM clock is the (prescaled) bus clock divided by ratio plus one.
// (R05) Software picks settings giving a 150 to 200 kHz NVM clock.
// (R06) Program/erase timed as integer count of NVM clock pulses.
// (R07) Layout bit 0 splits sectors over two pages; 1 keeps one page.
// (R08) Only security code 2'b10 means unsecured; other codes are secure.
// (R09) While secure, memory access by unsecured sources is blocked.
// (R10) Successful key compare or blank check sets security code to 2'b10.
// (R11) Page select 0 maps EEPROM page 0 in front, 1 maps page 1.
// (R12) Key window writes start commands, or load key when enabled.
// (R13) Unused register bits read zero and ignore writes.
module nvc_ctrl (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire nvc_pkg::nvc_sec_t I_NV_SEC,
  input wire logic I_KEY_MATCH,
  input wire logic I_BLANK_OK,
  input wire logic I_ACC_REQ,
  input wire logic I_ACC_SRC_SECURE,
  input wire logic I_WIN_WR,
  input wire logic [15:0] I_WIN_ADDR,
  input wire logic I_TMR_START,
  input wire nvc_pkg::nvc_pulse_cnt_t I_TMR_PULSES,
  output logic O_PE_ENABLE,
  output logic O_NVM_TICK,
  output logic O_TMR_BUSY,
  output logic O_TMR_DONE,
  output logic O_SECURE,
  output logic O_ACC_GRANT,
  output logic O_EE_PAGE_SEL,
  output logic O_EE_ONE_PAGE,
  output logic O_CMD_START,
  output logic O_KEY_WR,
  output logic [2:0] O_KEY_IDX
);
  import nvc_pkg::*;

  // ------------------------------------------------------------
  // AHB-Lite slave front end
  // ------------------------------------------------------------
  logic acc_ok, wr_pend_ff, rd_hit;
  logic [7:0] wr_addr_ff, rd_addr, rd_byte;
  assign acc_ok = I_HSEL && I_HREADY &&
                  (I_HTRANS == `NVC_HTRANS_NONSEQ ||
                   I_HTRANS == `NVC_HTRANS_SEQ);
  assign rd_addr = I_HADDR[7:0];
  assign rd_hit = (I_HADDR[31:8] == 24'h000000);

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= acc_ok && I_HWRITE && rd_hit;
      wr_addr_ff <= rd_addr;
    end
  end
  // Zero wait states and always OKAY: no register here needs a stall
  always_ff @(posedge I_CLK_SYS)
  begin
    O_HREADYOUT <= 1'b1;
    O_HRESP <= 1'b0;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic divisor_loaded_flag_ff, pre8_ff, layout_ff, pagesel_ff, keyen_ff, sec_loaded_ff;
  logic [`NVC_DIV_MSB:0] div_ff;
  nvc_sec_t sec_ff;
  logic wr_presc, wr_opt, wr_cfg, unsecured, unlock_evt;
  assign wr_presc = wr_pend_ff && wr_addr_ff == `NVC_OFS_PRESCALER;
  assign wr_opt = wr_pend_ff && wr_addr_ff == `NVC_OFS_OPTIONS;
  assign wr_cfg = wr_pend_ff && wr_addr_ff == `NVC_OFS_CONFIG;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      divisor_loaded_flag_ff <= 1'b0; // R01
      pre8_ff <= 1'b0;
      div_ff <= `NVC_DIV_RST;
    end
    else if (wr_presc)
    begin
      divisor_loaded_flag_ff <= 1'b1; // R01
      div_ff <= I_HWDATA[`NVC_DIV_MSB:0]; // R04
      if (!divisor_loaded_flag_ff)
        pre8_ff <= I_HWDATA[`NVC_BIT_PRESCALE_BY_EIGHT]; // R03
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      layout_ff <= 1'b0;
      pagesel_ff <= 1'b0;
      keyen_ff <= 1'b0;
    end
    else
    begin
      if (wr_opt)
        layout_ff <= I_HWDATA[`NVC_BIT_LAYOUT]; // R07
      if (wr_cfg)
      begin
        pagesel_ff <= I_HWDATA[`NVC_BIT_PAGESEL]; // R11
        keyen_ff <= I_HWDATA[`NVC_BIT_KEYEN]; // R12
      end
    end
  end

  // Code loads from the array once after reset; an unlock wins the tie
  assign unlock_evt = I_KEY_MATCH || I_BLANK_OK;
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      sec_ff <= `NVC_SEC_RST;
      sec_loaded_ff <= 1'b0;
    end
    else
    begin
      sec_loaded_ff <= 1'b1;
      if (unlock_evt)
        sec_ff <= `NVC_SEC_UNSECURED; // R10
      else if (!sec_loaded_ff)
        sec_ff <= I_NV_SEC;
    end
  end
  assign unsecured = (sec_ff == `NVC_SEC_UNSECURED); // R08
  // Read data registered in the address phase; unmapped reads give zero
  always_comb
  begin
    rd_byte = 8'h00; // R13
    unique case (rd_addr)
      `NVC_OFS_PRESCALER: rd_byte = {divisor_loaded_flag_ff, pre8_ff, div_ff};
      `NVC_OFS_OPTIONS: rd_byte = {2'h0, layout_ff, 3'h0, sec_ff};
      `NVC_OFS_CONFIG: rd_byte = {1'b0, pagesel_ff, keyen_ff, 5'h00};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      O_HRDATA <= 32'h00000000;
    else if (acc_ok && !I_HWRITE)
      O_HRDATA <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000; // R13
  end

  // ------------------------------------------------------------
  // NVM clock divider
  // ------------------------------------------------------------
  logic [2:0] pre_cnt_ff;
  logic [`NVC_DIV_MSB:0] div_cnt_ff;
  logic pre_en;
  // Divider runs only after a divisor is loaded, so no stray ticks
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST || !divisor_loaded_flag_ff)
      pre_cnt_ff <= 3'h0;
    else
      pre_cnt_ff <= pre_cnt_ff + 3'h1;
  end
  assign pre_en = !pre8_ff || (pre_cnt_ff == `NVC_PRE8_LAST); // R03
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST || !divisor_loaded_flag_ff)
    begin
      div_cnt_ff <= `NVC_DIV_RST;
      O_NVM_TICK <= 1'b0;
    end
    else
    begin
      O_NVM_TICK <= 1'b0;
      if (pre_en)
      begin
        if (div_cnt_ff >= div_ff)
        begin
          div_cnt_ff <= `NVC_DIV_RST;
          O_NVM_TICK <= 1'b1; // R04
        end
        else
          div_cnt_ff <= div_cnt_ff + 6'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Program/erase pulse timer
  // ------------------------------------------------------------
  nvc_tmr_state_t tmr_state_ff;
  nvc_pulse_cnt_t tmr_left_ff;
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      tmr_state_ff <= NVC_TMR_IDLE;
      tmr_left_ff <= 16'h0000;
      O_TMR_DONE <= 1'b0;
    end
    else
    begin
      O_TMR_DONE <= 1'b0;
      unique case (tmr_state_ff)
        NVC_TMR_IDLE:
          if (I_TMR_START && divisor_loaded_flag_ff && I_TMR_PULSES != 16'h0000) // R02
          begin
            tmr_state_ff <= NVC_TMR_RUN;
            tmr_left_ff <= I_TMR_PULSES; // R06
          end
        NVC_TMR_RUN:
          if (O_NVM_TICK)
          begin
            tmr_left_ff <= tmr_left_ff - 16'h0001; // R06
            if (tmr_left_ff == 16'h0001)
            begin
              tmr_state_ff <= NVC_TMR_IDLE;
              O_TMR_DONE <= 1'b1;
            end
          end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Status, access gating and key window
  // ------------------------------------------------------------
  logic in_win;
  assign in_win = I_WIN_ADDR >= `NVC_KEY_WIN_LO &&
                  I_WIN_ADDR <= `NVC_KEY_WIN_HI;
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      O_PE_ENABLE <= 1'b0;
      O_TMR_BUSY <= 1'b0;
      O_SECURE <= 1'b1;
      O_ACC_GRANT <= 1'b0;
      O_EE_PAGE_SEL <= 1'b0;
      O_EE_ONE_PAGE <= 1'b0;
      O_CMD_START <= 1'b0;
      O_KEY_WR <= 1'b0;
      O_KEY_IDX <= 3'h0;
    end
    else
    begin
      O_PE_ENABLE <= divisor_loaded_flag_ff; // R02
      O_TMR_BUSY <= (tmr_state_ff == NVC_TMR_RUN);
      O_SECURE <= !unsecured; // R08
      O_ACC_GRANT <= I_ACC_REQ && (unsecured || I_ACC_SRC_SECURE); // R09
      O_EE_PAGE_SEL <= pagesel_ff; // R11
      O_EE_ONE_PAGE <= layout_ff; // R07
      // Commands are dropped, not queued, until a divisor is loaded
      O_CMD_START <= I_WIN_WR && in_win && !keyen_ff && divisor_loaded_flag_ff; // R12 R02
      O_KEY_WR <= I_WIN_WR && in_win && keyen_ff; // R12
      O_KEY_IDX <= I_WIN_ADDR[2:0];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_first_presc_wr;
    wr_presc && !divisor_loaded_flag_ff;
  endsequence
  sequence s_flag_up;
    divisor_loaded_flag_ff ##1 O_PE_ENABLE;
  endsequence

  divisor_loaded_flag_set_a: assert property ( // R01
    @(posedge I_CLK_SYS) disable iff (I_RST)
    s_first_presc_wr |=> s_flag_up)
    else $error("flag not set by first prescaler write");
  pe_inhibit_a: assert property ( // R02
    @(posedge I_CLK_SYS) disable iff (I_RST)
    !divisor_loaded_flag_ff |=> !O_CMD_START && !O_PE_ENABLE && !O_NVM_TICK)
    else $error("program or erase enabled before divisor load");
  pre8_once_a: assert property ( // R03
    @(posedge I_CLK_SYS) disable iff (I_RST)
    divisor_loaded_flag_ff |=> $stable(pre8_ff))
    else $error("prescale bit changed after first write");
  tick_space_a: assert property ( // R04
    @(posedge I_CLK_SYS) disable iff (I_RST)
    O_NVM_TICK && !pre8_ff && div_ff == 6'h02 && $stable(div_ff)
    |=> !O_NVM_TICK [*2] ##1 O_NVM_TICK)
    else $error("divide by ratio plus one broken");
  tmr_count_a: assert property ( // R06
    @(posedge I_CLK_SYS) disable iff (I_RST)
    tmr_state_ff == NVC_TMR_RUN && O_NVM_TICK && tmr_left_ff == 16'h0001
    |=> O_TMR_DONE && tmr_state_ff == NVC_TMR_IDLE)
    else $error("timer did not finish on last pulse");
  sec_decode_a: assert property ( // R08
    @(posedge I_CLK_SYS) disable iff (I_RST)
    ##1 O_SECURE == ($past(sec_ff) != `NVC_SEC_UNSECURED))
    else $error("security decode wrong");
  acc_block_a: assert property ( // R09
    @(posedge I_CLK_SYS) disable iff (I_RST)
    !unsecured && !I_ACC_SRC_SECURE |=> !O_ACC_GRANT)
    else $error("unsecured access granted while secure");
  unlock_a: assert property ( // R10
    @(posedge I_CLK_SYS) disable iff (I_RST)
    unlock_evt |=> sec_ff == 2'h2 ##1 !O_SECURE)
    else $error("unlock did not clear security");
  page_map_a: assert property ( // R11
    @(posedge I_CLK_SYS) disable iff (I_RST)
    wr_cfg |=> ##1 O_EE_PAGE_SEL == $past(I_HWDATA[`NVC_BIT_PAGESEL], 2))
    else $error("page select not followed");
  key_route_a: assert property ( // R12
    @(posedge I_CLK_SYS) disable iff (I_RST)
    I_WIN_WR && in_win && keyen_ff |=> O_KEY_WR && !O_CMD_START)
    else $error("key window write misrouted");
  unused_zero_a: assert property ( // R13
    @(posedge I_CLK_SYS) disable iff (I_RST)
    acc_ok && !I_HWRITE |=> O_HRDATA[31:8] == 24'h000000)
    else $error("unused bits read nonzero");
endmodule

// ---- tb/nvc_array_model.sv ----
// Behavioural model of the NVM arrays facing the control block
module nvc_array_model (
  input wire logic clk,
  input wire nvc_pkg::nvc_sec_t i_code,
  input wire logic i_key_wr,
  input wire logic [2:0] i_key_idx,
  input wire logic i_cmd_start,
  input wire logic i_blank,
  output nvc_pkg::nvc_sec_t o_nv_sec,
  output logic o_key_match,
  output logic o_blank_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  logic [7:0] seen_ff = 8'h00;
  // Stored code as the array holds it across resets
  assign o_nv_sec = i_code;
  always @(posedge clk)
  begin
    o_key_match <= 1'b0;
    o_blank_ok <= 1'b0;
    // Compare succeeds only once all eight key bytes have landed
    if (i_key_wr && ((seen_ff | (8'h01 << i_key_idx)) == 8'hff))
    begin
      o_key_match <= 1'b1;
      seen_ff <= 8'h00;
    end
    else if (i_key_wr)
      seen_ff <= seen_ff | (8'h01 << i_key_idx);
    if (i_cmd_start && i_blank)
      o_blank_ok <= 1'b1;
  end
endmodule

// ---- tb/tb_nvm_clock_security_config.sv ----
// Self-checking bench for the NVM clock, security and configuration block
module tb_nvm_clock_security_config;
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, blank = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  nvc_sec_t code = 2'h3, nv_sec;
  logic acc_req = 1'b0, acc_sec = 1'b0, win_wr = 1'b0, tmr_start = 1'b0;
  logic [15:0] win_addr = 16'h0;
  nvc_pulse_cnt_t pulses = 16'h0;
  logic hready, hresp, pe, tick, busy, done, secure, grant, pgsel, onepg;
  logic cmd, keywr, key_match, blank_ok, rd_dp = 1'b0;
  logic [2:0] keyidx;
  logic [31:0] exp_q[$];
  int n_mismatch = 0, compares = 0, cyc = 0, seed = 68099;
  int i, k, n, s, r, p, t;

  always #20 clk = ~clk;

  nvc_ctrl nvc_ctrl_i (.I_CLK_SYS(clk), .I_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_NV_SEC(nv_sec),
    .I_KEY_MATCH(key_match), .I_BLANK_OK(blank_ok), .I_ACC_REQ(acc_req),
    .I_ACC_SRC_SECURE(acc_sec), .I_WIN_WR(win_wr), .I_WIN_ADDR(win_addr),
    .I_TMR_START(tmr_start), .I_TMR_PULSES(pulses), .O_PE_ENABLE(pe),
    .O_NVM_TICK(tick), .O_TMR_BUSY(busy), .O_TMR_DONE(done),
    .O_SECURE(secure), .O_ACC_GRANT(grant), .O_EE_PAGE_SEL(pgsel),
    .O_EE_ONE_PAGE(onepg), .O_CMD_START(cmd), .O_KEY_WR(keywr),
    .O_KEY_IDX(keyidx));

  nvc_array_model nvc_array_model_i (.clk(clk), .i_code(code),
    .i_key_wr(keywr), .i_key_idx(keyidx), .i_cmd_start(cmd),
    .i_blank(blank), .o_nv_sec(nv_sec), .o_key_match(key_match),
    .o_blank_ok(blank_ok));

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
  begin
    compares++;
    if (v !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  end
  endtask

  task automatic test_done();
  begin
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // Read data is judged when its data phase completes
  always @(posedge clk)
  begin
    if (rd_dp && hready === 1'b1)
    begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 0, hresp);
    end
    if (hready === 1'b1)
      rd_dp <= hsel && htrans[1] && !hwrite;
  end

  // Cycle ceiling sized well above the longest run of all passes
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
  begin
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  end
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] e);
  begin
    exp_q.push_back(e);
    bus(1'b0, a, hwdata);
  end
  endtask

  task automatic win(logic [15:0] a, logic ek, logic ec, logic [2:0] ei);
  begin
    @(posedge clk);
    win_wr <= 1'b1;
    win_addr <= a;
    @(posedge clk);
    win_wr <= 1'b0;
    #1;
    chk("key_wr", ek, keywr);
    chk("cmd_start", ec, cmd);
    if (ek)
      chk("key_idx", ei, keyidx);
  end
  endtask

  task automatic acc(logic sv, logic e);
  begin
    @(posedge clk);
    acc_req <= 1'b1;
    acc_sec <= sv;
    repeat (2) @(posedge clk);
    #1;
    chk("grant", e, grant);
  end
  endtask

  task automatic period(int e);
  begin
    do @(posedge clk); while (tick !== 1'b1);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tick !== 1'b1);
    chk("tick_period", e, n);
  end
  endtask

  task automatic timer(int np);
  begin
    @(posedge clk);
    tmr_start <= 1'b1;
    pulses <= np[15:0];
    @(posedge clk);
    tmr_start <= 1'b0;
    k = 0;
    repeat (700)
    begin
      @(posedge clk);
      if (done === 1'b1)
        break;
      k += int'(tick === 1'b1);
    end
    chk("tmr_pulses", np, k);
    chk("tmr_done", 1, done);
    chk("tmr_busy", 1, busy);
    @(posedge clk);
    chk("tmr_busy", 0, busy);
  end
  endtask

  // ----------------------------------------
  // Scenarios: five passes over the four stored security codes, code 2'b11 in the first and last
  // ----------------------------------------
  initial
  begin
    for (t = 0; t < 5; t++)
    begin
      @(posedge clk);
      rst <= 1'b1;
      code <= (t == 0) ? 2'h3 : 2'(t - 1);
      blank <= 1'b0;
      acc_req <= 1'b0;
      repeat (t == 0 ? 12 : 2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("secure", code != 2'h2, secure);
      chk("pe_enable", 0, pe);
      // A timer start before the divisor is loaded must be ignored
      @(posedge clk);
      tmr_start <= 1'b1;
      pulses <= 16'h0001;
      @(posedge clk);
      tmr_start <= 1'b0;
      repeat (2) @(posedge clk);
      chk("tmr_busy", 0, busy);
      rd(32'h0, 32'h0);
      rd(32'h4, 32'(code));
      win(16'hffb0, 0, 0, 0);
      p = (t == 0);
      // Without the divide by 8 no ratio reaches the NVM clock band here
      r = p ? 15 + ($random(seed) & 3) : 5;
      bus(1, 32'h0, 32'(p * 64 + r));
      rd(32'h0, 32'(128 + p * 64 + r));
      bus(1, 32'h0, 32'(128 + (1 - p) * 64 + r));
      rd(32'h0, 32'(128 + p * 64 + r));
      chk("pe_enable", 1, pe);
      period((r + 1) * (p ? 8 : 1));
      if (p)
      begin
        timer(1 + ($random(seed) & 3));
        rd(32'hc, 32'h0);
        rd(32'h100, 32'h0);
        win(16'hffb0, 0, 1, 0);
        acc(0, 0);
        acc(1, 1);
        bus(1, 32'h8, 32'h20);
        win(16'hffb8, 0, 0, 0);
        s = $random(seed) & 7;
        for (i = 0; i < 8; i++)
          win(16'hffb0 + 16'(i ^ s), 1, 0, 3'(i ^ s));
      end
      else
      begin
        bus(1, 32'h0, 32'h2);
        rd(32'h0, 32'h82);
        period(3);
        blank <= 1'b1;
        win(16'hffb0, 0, 1, 0);
      end
      repeat (3) @(posedge clk);
      #1;
      chk("secure", 0, secure);
      acc(0, 1);
      for (i = 0; i < 2 && p; i++)
      begin
        bus(1, 32'h4, i ? 32'hff : 32'h0);
        bus(1, 32'h8, i ? 32'hff : 32'h0);
        rd(32'h4, i ? 32'h22 : 32'h2);
        rd(32'h8, i ? 32'h60 : 32'h0);
        chk("one_page", i, onepg);
        chk("page_sel", i, pgsel);
      end
      $display("test %0d done", t);
    end
    test_done();
  end
endmodule
